// *** pkg/bbs_pkg.sv ***
// Package: offsets, field layout and reset values of the bus, I/O window and status registers
package bbs_pkg;

   localparam logic [11:0] BUS_NUMBERS_OFFSET   = 12'h018;
   localparam logic [11:0] IO_STATUS_OFFSET     = 12'h01C;
   localparam logic [11:0] IO_UPPER_OFFSET      = 12'h030;
   localparam logic [11:0] ENABLES_OFFSET       = 12'h040;
   localparam logic [11:0] WINDOW_PROBE_OFFSET  = 12'h044;

   localparam int DOWN_BUS_LSB      = 8;
   localparam int HIGH_BUS_LSB      = 16;
   localparam int LATENCY_LSB       = 24;
   localparam int IO_CAP_BOTTOM_LSB = 0;
   localparam int IO_BOTTOM_LSB     = 4;
   localparam int IO_CAP_TOP_LSB    = 8;
   localparam int IO_TOP_LSB        = 12;
   localparam int FLAG_PARITY_BIT   = 24;
   localparam int FLAG_SIG_ABORT    = 27;
   localparam int FLAG_RCV_ABORT    = 28;
   localparam int FLAG_RCV_UNSUP    = 29;
   localparam int FLAG_SYS_ERROR    = 30;
   localparam int FLAG_POISONED     = 31;
   localparam int ENA_PARITY_BIT    = 0;
   localparam int ENA_SYS_ERR_BIT   = 1;

   localparam logic [7:0]  BUS_NUMBER_RESET = 8'h00;
   localparam logic [7:0]  LATENCY_VALUE    = 8'h00;
   localparam logic [3:0]  IO_CAP_VALUE     = 4'h1;
   localparam logic [3:0]  IO_FIELD_RESET   = 4'h0;
   localparam logic [11:0] IO_LOW_ZERO      = 12'h000;
   localparam logic [11:0] IO_LOW_ONES      = 12'hFFF;
   localparam logic [15:0] IO_UPPER_RESET   = 16'h0000;
   localparam logic [31:0] WRITE_CLEAR_MASK = 32'hC1000000;
   localparam logic [31:0] SLVERR_DATA      = 32'h00000000;

   typedef struct packed {
      logic parity_error;
      logic completer_abort_sent;
      logic completer_abort_received;
      logic unsupported_received;
      logic fatal_or_nonfatal_sent;
      logic poisoned_received;
   } bbs_event_type;

endpackage : bbs_pkg

// *** core/bbs_regs.sv ***
// Downstream bus numbers, I/O forwarding window and downstream status flags over APB
//
// Chosen here: register access over APB.
module bbs_regs
(
   input  wire logic                  clock,
   input  wire logic                  rst,
   input  wire logic                  clock_enable,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   input  wire logic [3:0]            pstrb,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire bbs_pkg::bbs_event_type events,
   input  wire logic [31:0]           io_address,
   output logic                       io_forward,
   output logic      [7:0]            downstream_bus_number,
   output logic      [7:0]            highest_downstream_bus_number
);

   logic [3:0]  io_window_bottom;
   logic [3:0]  io_window_top;
   logic [15:0] io_bottom_upper;
   logic [15:0] io_top_upper;
   logic        parity_response_enable;
   logic        system_error_report_enable;
   logic        flag_parity;
   logic        flag_sig_abort;
   logic        flag_rcv_abort;
   logic        flag_unsup;
   logic        flag_sys_error;
   logic        flag_poisoned;
   logic        rd_loaded;
   wire  [5:0]  flags = {flag_poisoned, flag_sys_error, flag_unsup,
                         flag_rcv_abort, flag_sig_abort, flag_parity};
   logic        forward_q;
   logic [31:0] next_prdata;
   logic        next_pslverr;

   wire access     = psel & penable;
   wire write_en   = access & pwrite & clock_enable;
   wire read_en    = access & ~pwrite & clock_enable;
   // Exact word match; a partial decode would alias the window registers
   function automatic logic bbs_hit(input logic [11:0] addr, input logic [11:0] offset);
      bbs_hit = (addr == offset);
   endfunction : bbs_hit

   wire hit_bus    = bbs_hit(paddr, bbs_pkg::BUS_NUMBERS_OFFSET);
   wire hit_io     = bbs_hit(paddr, bbs_pkg::IO_STATUS_OFFSET);
   wire hit_upper  = bbs_hit(paddr, bbs_pkg::IO_UPPER_OFFSET);
   wire hit_ena    = bbs_hit(paddr, bbs_pkg::ENABLES_OFFSET);
   wire hit_probe  = bbs_hit(paddr, bbs_pkg::WINDOW_PROBE_OFFSET);
   wire mapped     = hit_bus | hit_io | hit_upper | hit_ena | hit_probe;

   // Byte-lane merge for writable fields
   function automatic logic [31:0] bbs_lane_mask(input logic [3:0] strb);
      bbs_lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction : bbs_lane_mask

   wire [31:0] lanes      = bbs_lane_mask(pstrb);
   wire [31:0] wdata_m    = pwdata & lanes;
   wire        wr_bus     = write_en & hit_bus;
   wire        wr_io      = write_en & hit_io;
   wire        wr_upper   = write_en & hit_upper;
   wire        wr_ena     = write_en & hit_ena;

   // Only bits 24, 30 and 31 are clearable; aborts stay until reset
   wire [31:0] clear_word = wr_io ? (wdata_m & bbs_pkg::WRITE_CLEAR_MASK) : 32'h00000000;
   wire [5:0]  clear_vec  = {clear_word[bbs_pkg::FLAG_POISONED],
                             clear_word[bbs_pkg::FLAG_SYS_ERROR],
                             1'b0, 1'b0, 1'b0,
                             clear_word[bbs_pkg::FLAG_PARITY_BIT]};
   wire [5:0]  set_vec    = {events.poisoned_received,
                             events.fatal_or_nonfatal_sent & system_error_report_enable,
                             events.unsupported_received,
                             events.completer_abort_received,
                             events.completer_abort_sent,
                             events.parity_error & parity_response_enable};
   // Set wins over a clear in the same cycle
   wire [5:0]  next_flags = set_vec | (flags & ~clear_vec);

   wire [15:0] status_word = {flags[5], flags[4], flags[3], flags[2], flags[1],
                              2'b00,
                              flags[0],
                              1'b0, 1'b0, 1'b0,
                              5'b00000};

   wire [31:0] bus_word   = {bbs_pkg::LATENCY_VALUE,
                             highest_downstream_bus_number,
                             downstream_bus_number, 8'h00};
   wire [31:0] io_word    = {status_word, io_window_top, bbs_pkg::IO_CAP_VALUE,
                             io_window_bottom, bbs_pkg::IO_CAP_VALUE};
   wire [31:0] upper_word = {io_top_upper, io_bottom_upper};
   wire [31:0] ena_word   = {30'h00000000, system_error_report_enable, parity_response_enable};

   // Window bounds: low 12 bits zero for start, ones for end
   wire [31:0] window_start = {io_bottom_upper, io_window_bottom, bbs_pkg::IO_LOW_ZERO};
   wire [31:0] window_end   = {io_top_upper, io_window_top, bbs_pkg::IO_LOW_ONES};
   wire        in_window    = (io_address >= window_start) && (io_address <= window_end);

   always_comb
   begin
      next_prdata  = bbs_pkg::SLVERR_DATA;
      next_pslverr = 1'b0;
      if (hit_bus)
      begin
         next_prdata = bus_word;
      end
      else if (hit_io)
      begin
         next_prdata = io_word;
      end
      else if (hit_upper)
      begin
         next_prdata = upper_word;
      end
      else if (hit_ena)
      begin
         next_prdata = ena_word;
      end
      else if (hit_probe)
      begin
         next_prdata = {31'h00000000, forward_q};
      end
      else
      begin
         next_pslverr = 1'b1;
      end
   end

   // Read data is normally loaded in setup; a setup edge lost to a
   // frozen enable costs one wait state to load it late
   wire read_setup = psel & ~penable & ~pwrite;
   wire read_late  = access & ~pwrite & ~rd_loaded;
   wire load_rd    = (read_setup | read_late) & clock_enable;
   wire rd_done    = access & ~pwrite & rd_loaded & clock_enable;

   // Zero-wait slave; a frozen clock enable stalls the access
   assign pready     = clock_enable & (pwrite | rd_loaded | ~access);
   assign pslverr    = access & ~mapped;
   assign io_forward = forward_q;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         downstream_bus_number         <= bbs_pkg::BUS_NUMBER_RESET;
         highest_downstream_bus_number <= bbs_pkg::BUS_NUMBER_RESET;
      end
      else if (wr_bus)
      begin
         if (pstrb[1])
         begin
            downstream_bus_number <= wdata_m[bbs_pkg::DOWN_BUS_LSB +: 8];
         end
         if (pstrb[2])
         begin
            highest_downstream_bus_number <= wdata_m[bbs_pkg::HIGH_BUS_LSB +: 8];
         end
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         io_window_bottom <= bbs_pkg::IO_FIELD_RESET;
         io_window_top    <= bbs_pkg::IO_FIELD_RESET;
      end
      else if (wr_io)
      begin
         if (pstrb[0])
         begin
            io_window_bottom <= wdata_m[bbs_pkg::IO_BOTTOM_LSB +: 4];
         end
         if (pstrb[1])
         begin
            io_window_top <= wdata_m[bbs_pkg::IO_TOP_LSB +: 4];
         end
      end
   end

   // Window start, address bits 31:16, byte lanes 0 and 1
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         io_bottom_upper <= bbs_pkg::IO_UPPER_RESET;
      end
      else if (wr_upper)
      begin
         io_bottom_upper <= (io_bottom_upper & ~lanes[15:0]) | wdata_m[15:0];
      end
   end

   // Window end, address bits 31:16, byte lanes 2 and 3
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         io_top_upper <= bbs_pkg::IO_UPPER_RESET;
      end
      else if (wr_upper)
      begin
         io_top_upper <= (io_top_upper & ~lanes[31:16]) | wdata_m[31:16];
      end
   end

   // Enables only gate set events; they never clear a flag
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         parity_response_enable <= 1'b0;
      end
      else if (wr_ena && pstrb[0])
      begin
         parity_response_enable <= pwdata[bbs_pkg::ENA_PARITY_BIT];
      end
   end

   // System error reporting enable, lane 0
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         system_error_report_enable <= 1'b0;
      end
      else if (wr_ena && pstrb[0])
      begin
         system_error_report_enable <= pwdata[bbs_pkg::ENA_SYS_ERR_BIT];
      end
   end

   // One cycle from io_address to io_forward
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         forward_q <= 1'b0;
      end
      else if (clock_enable)
      begin
         forward_q <= in_window;
      end
   end

   // Parity error, bit 24
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         flag_parity <= 1'b0;
      end
      else if (clock_enable)
      begin
         flag_parity <= next_flags[0];
      end
   end

   // Completer abort sent, bit 27
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         flag_sig_abort <= 1'b0;
      end
      else if (clock_enable)
      begin
         flag_sig_abort <= next_flags[1];
      end
   end

   // Completer abort received, bit 28
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         flag_rcv_abort <= 1'b0;
      end
      else if (clock_enable)
      begin
         flag_rcv_abort <= next_flags[2];
      end
   end

   // Unsupported request received, bit 29
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         flag_unsup <= 1'b0;
      end
      else if (clock_enable)
      begin
         flag_unsup <= next_flags[3];
      end
   end

   // Fatal or nonfatal message sent, bit 30
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         flag_sys_error <= 1'b0;
      end
      else if (clock_enable)
      begin
         flag_sys_error <= next_flags[4];
      end
   end

   // Poisoned packet received, bit 31
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         flag_poisoned <= 1'b0;
      end
      else if (clock_enable)
      begin
         flag_poisoned <= next_flags[5];
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         prdata <= 32'h00000000;
      end
      else if (load_rd)
      begin
         // Captured in setup, or in the first enabled access cycle if setup was frozen, so data stands when pready is high
         prdata <= next_prdata;
      end
      else if (read_en && next_pslverr)
      begin
         prdata <= bbs_pkg::SLVERR_DATA;
      end
   end

   // Marks that prdata holds the word of the read in progress
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         rd_loaded <= 1'b0;
      end
      else if (load_rd)
      begin
         rd_loaded <= 1'b1;
      end
      else if (rd_done || (clock_enable && !psel))
      begin
         rd_loaded <= 1'b0;
      end
   end

endmodule : bbs_regs

// *** verification/bbs_regs_props.sv ***
// Checker: bus number fields and constant read-back fields of the register block
module bbs_regs_props
(
   input wire logic                   clock,
   input wire logic                   rst,
   input wire logic                   clock_enable,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [11:0]            paddr,
   input wire logic [31:0]            pwdata,
   input wire logic [3:0]             pstrb,
   input wire logic [31:0]            prdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   input wire bbs_pkg::bbs_event_type events,
   input wire logic [31:0]            io_address,
   input wire logic                   io_forward,
   input wire logic [7:0]             downstream_bus_number,
   input wire logic [7:0]             highest_downstream_bus_number
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   // Access phase that completes this cycle
   sequence s_access(addr);
      psel && penable && clock_enable && pready && paddr == addr;
   endsequence
   a_bus_write: assert property (
      s_access(12'h018) ##0 (pwrite && pstrb[1]) |=> downstream_bus_number == $past(pwdata[15:8]))
      else $error("Downstream bus number write lost");
   a_high_write: assert property (
      s_access(12'h018) ##0 (pwrite && pstrb[2])
      |=> highest_downstream_bus_number == $past(pwdata[23:16]))
      else $error("Highest bus number write lost");
   a_bus_hold: assert property (
      !(psel && penable && pwrite && clock_enable && paddr == 12'h018 && pstrb[1])
      |=> $stable(downstream_bus_number)) else $error("Downstream bus number changed");
   a_high_hold: assert property (
      !(psel && penable && pwrite && clock_enable && paddr == 12'h018 && pstrb[2])
      |=> $stable(highest_downstream_bus_number)) else $error("Highest bus number changed");
   a_reset_clear: assert property (
      $fell(rst) |-> downstream_bus_number == 8'h00 && highest_downstream_bus_number == 8'h00)
      else $error("Bus numbers not cleared by reset");
   a_latency_zero: assert property (
      s_access(12'h018) ##0 !pwrite |-> prdata[31:24] == 8'h00)
      else $error("Latency byte not zero");
   a_cap_ones: assert property (
      s_access(12'h01C) ##0 !pwrite |-> prdata[3:0] == 4'h1 && prdata[11:8] == 4'h1)
      else $error("I/O capability nibbles not one");
   a_legacy_zero: assert property (
      s_access(12'h01C) ##0 !pwrite |-> prdata[23:16] == 8'h00 && prdata[26:25] == 2'h0)
      else $error("Legacy status bits not zero");
endmodule : bbs_regs_props
bind bbs_regs bbs_regs_props u_props (.clock(clock), .rst(rst), .clock_enable(clock_enable),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(events),
   .io_address(io_address), .io_forward(io_forward),
   .downstream_bus_number(downstream_bus_number),
   .highest_downstream_bus_number(highest_downstream_bus_number));

// *** verification/tb_top.sv ***
// Testbench: APB scenarios for bus numbers, I/O window and downstream status
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic                   clock = 0, rst = 1, clock_enable = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0]            paddr = 12'h000;
   logic [31:0]            pwdata = 32'h00000000, io_address = 32'h00000000, prdata, rd;
   logic [3:0]             pstrb = 4'h0;
   logic                   pready, pslverr, io_forward, er;
   logic [7:0]             dbn, hbn;
   bbs_pkg::bbs_event_type ev = 6'h00;
   int                     err_count = 0, compares = 0;
   bbs_regs u_bbs_regs (.clock(clock), .rst(rst), .clock_enable(clock_enable), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(ev), .io_address(io_address),
      .io_forward(io_forward), .downstream_bus_number(dbn), .highest_downstream_bus_number(hbn));
   initial
   begin
      forever #25 clock = ~clock;
   end
   task automatic finish_test;
      $display("compares %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         $display("ERROR %s expected %h seen %h", name, exp, got);
         err_count++;
      end
   endtask : chk
   // Request held until the edge at which pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      bit done;
      done = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clock);
      penable <= 1'b1;
      for (int n = 0; n < 16 && !done; n++)
      begin
         @(posedge clock);
         done = (pready === 1'b1);
         rd = prdata;
         er = pslverr;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      if (!done)
      begin
         err_count++;
         finish_test();
      end
   endtask : apb
   task automatic t_reset;
      apb(0, 12'h018, 0, 0);
      chk("bus word", 32'h00000000, rd);
      apb(0, 12'h01C, 0, 0);
      chk("io status word", 32'h00000101, rd);
      apb(0, 12'h100, 0, 0);
      chk("unmapped error", 32'h00000001, {31'h0, er});
   endtask : t_reset
   task automatic t_bus;
      apb(1, 12'h018, 32'hFFFFFFFF, 4'hF);
      apb(0, 12'h018, 0, 0);
      chk("bus word", 32'h00FFFF00, rd);
      apb(1, 12'h018, 32'h00A55A00, 4'h2);
      apb(0, 12'h018, 0, 0);
      chk("bus word", 32'h00FF5A00, rd);
      chk("bus ports", 32'h0000FF5A, {16'h0, hbn, dbn});
   endtask : t_bus
   task automatic t_freeze;
      // Enable low over the setup edge: write waits, read loads late
      clock_enable <= 1'b0;
      fork
         apb(1, 12'h018, 32'h00003C00, 4'h2);
         begin
            repeat (4) @(posedge clock);
            chk("frozen bus number", 32'h0000005A, {24'h0, dbn});
            clock_enable <= 1'b1;
         end
      join
      @(posedge clock);
      chk("thawed bus number", 32'h0000003C, {24'h0, dbn});
      clock_enable <= 1'b0;
      fork
         apb(0, 12'h018, 0, 0);
         begin
            repeat (3) @(posedge clock);
            clock_enable <= 1'b1;
         end
      join
      chk("late read word", 32'h00FF3C00, rd);
   endtask : t_freeze
   task automatic probe(input logic [31:0] a, input logic exp);
      @(posedge clock);
      io_address <= a;
      @(posedge clock);
      @(negedge clock);
      chk("io forward", {31'h0, exp}, {31'h0, io_forward});
   endtask : probe
   task automatic t_window;
      apb(1, 12'h030, 32'h00010001, 4'hF);
      apb(1, 12'h01C, 32'h00003020, 4'h3);
      apb(0, 12'h01C, 0, 0);
      chk("io status word", 32'h00003121, rd);
      probe(32'h00011FFF, 0);
      probe(32'h00012000, 1);
      probe(32'h00013FFF, 1);
      probe(32'h00014000, 0);
      probe(32'h00002000, 0);
   endtask : t_window
   task automatic pulse(input logic [5:0] e);
      @(posedge clock);
      ev <= e;
      @(posedge clock);
      ev <= 6'h00;
   endtask : pulse
   task automatic t_flags;
      pulse(6'h3F);
      apb(0, 12'h01C, 0, 0);
      chk("status gated", 32'hB8003121, rd);
      apb(1, 12'h040, 32'h00000003, 4'h1);
      pulse(6'h3F);
      apb(0, 12'h01C, 0, 0);
      chk("status all set", 32'hF9003121, rd);
      // Parity held high across the clear write
      ev <= 6'h20;
      apb(1, 12'h01C, 32'hFF000000, 4'h8);
      ev <= 6'h00;
      apb(0, 12'h01C, 0, 0);
      chk("status set wins", 32'h39003121, rd);
      apb(1, 12'h01C, 32'h01000000, 4'h8);
      apb(0, 12'h01C, 0, 0);
      chk("status cleared", 32'h38003121, rd);
   endtask : t_flags
   initial
   begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      t_reset();
      t_bus();
      t_freeze();
      t_window();
      t_flags();
      finish_test();
   end
endmodule : tb_top
